// [laser_status_fault_sequencer_test.sv]
/*
 * Bench for the status and fault sequencer: a table of fault cases,
 * then warm-up, shutter, guard, pulse limit and no-strike runs.
 * Assumes lfs_top with short counts and lfs_ctrl_model at its inputs.
 */
`timescale 1ns/100ps

module laser_status_fault_sequencer_test;
    import lfs_pkg::*;

    // ****************************************************
    // Stimulus, table and checks
    // ****************************************************
    typedef struct packed {
        logic g;
        logic [5:0] f;
        logic [4:0] e;
        logic [2:0] code;
    } lfs_row_t;
    // Faults: temp, undervolt, overvolt, switch, drive, supply
    // Expect: ready out, fault out, interlock out, coolant, guard lamp
    lfs_row_t rows [9] = '{
        '{1'h1, 6'h10, 5'h03, 3'h1}, '{1'h1, 6'h00, 5'h13, 3'h0},
        '{1'h0, 6'h00, 5'h06, 3'h0}, '{1'h1, 6'h20, 5'h09, 3'h0},
        '{1'h1, 6'h08, 5'h03, 3'h2}, '{1'h1, 6'h04, 5'h13, 3'h3},
        '{1'h1, 6'h02, 5'h13, 3'h4}, '{1'h1, 6'h01, 5'h03, 3'h5},
        '{1'h1, 6'h11, 5'h03, 3'h1}};
    logic clk = 1'h0;
    logic rst_n = 1'h0;
    logic guard = 1'h0;
    logic shut = 1'h0;
    logic nostrike = 1'h0;
    logic humid = 1'h0;
    logic [5:0] flt = 6'h00;
    logic [7:0] per = 8'h00;
    logic [7:0] high = 8'h00;
    logic g_w, s_w, p_w;
    wire [12:0] ob; // Lamps 0-4, drives 5-7, mirrored 8-12
    int mismatches = 0;
    int num_checks = 0;
    int hi, run, ris, n;
    localparam int WRM = 20, PSE = 12, BLK = 3, STL = 10, WID = 40, FRQ = 8;

    // Clock and far side
    always #2.5 clk = ~clk;
    lfs_ctrl_model ctl_u (.clk_i(clk), .guard_i(guard), .shut_i(shut),
        .per_i(per), .high_i(high), .guard_o(g_w), .shut_o(s_w),
        .pulse_o(p_w));
    lfs_top #(.WARM_CYC(WRM), .PAUSE_CYC(PSE), .BLINK_ON_CYC(BLK),
        .BLINK_OFF_CYC(BLK), .SETTLE_CYC(STL), .WIDTH_CYC(WID),
        .FREQ_CYC(FRQ)) dut_u (
        .CLK_I(clk), .RST_N_I(rst_n), .GUARD_LOOP_I(g_w),
        .SHUTTER_REQ_I(s_w), .PULSE_CMD_I(p_w), .OVER_TEMP_I(flt[5]),
        .UNDER_VOLT_I(flt[4]), .OVER_VOLT_I(flt[3]),
        .RF_SWITCH_FAIL_I(flt[2]), .PULSE_DRIVE_FAIL_I(flt[1]),
        .PRECHARGE_FAIL_I(flt[0]), .NO_STRIKE_I(nostrike),
        .HUMIDITY_I(humid), .READY_LAMP_O(ob[0]), .GUARD_LAMP_O(ob[1]),
        .COOLANT_HEAT_LAMP_O(ob[2]), .SHUTTER_LAMP_O(ob[3]),
        .EMISSION_LAMP_O(ob[4]), .SHUTTER_DRIVE_O(ob[5]),
        .TICKLE_EN_O(ob[6]), .RF_PULSE_O(ob[7]), .READY_OUT_O(ob[8]),
        .FAULT_OUT_O(ob[9]), .SHUTTER_OUT_O(ob[10]), .LASE_OUT_O(ob[11]),
        .INTERLOCK_OUT_O(ob[12]));

    // Comparison, counted
    task automatic check(input string nm, input logic [15:0] s, e);
        num_checks++;
        if (s !== e) begin
            mismatches++;
            $display("[FAIL] %s expected %0h seen %0h", nm, e, s);
        end
    endtask

    // Verdict and end of run
    task automatic test_done();
        $display("Checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // Cycle helpers, all on falling edges
    task automatic cyc(input int k);
        repeat (k) @(negedge clk);
    endtask
    task automatic do_reset();
        rst_n = 1'h0;
        cyc(2);
        rst_n = 1'h1;
        cyc(2);
    endtask
    function automatic logic [15:0] mir();
        return 16'({ob[8], ob[9], ob[12], ob[2], ob[1]});
    endfunction

    // Waits for an output to rise, bounded
    task automatic await(input int idx, input int lim);
        int t;
        t = 0;
        while (ob[idx] !== 1'h1 && t < lim) begin
            cyc(1);
            t++;
        end
        check("rise", 16'(idx), 16'(ob[idx] === 1'h1 ? idx : 99));
    endtask

    // High cycles, longest high run and rises of one output
    task automatic scan(input int idx, k, output int h, r, rs);
        int cur;
        logic last;
        cur = 0;
        h = 0;
        r = 0;
        rs = 0;
        last = ob[idx];
        repeat (k) begin
            cyc(1);
            cur = (ob[idx] === 1'h1) ? cur + 1 : 0;
            h += (cur > 0);
            rs += (cur == 1 && last !== 1'h1);
            r = (cur > r) ? cur : r;
            last = ob[idx];
        end
    endtask

    // Blinks of the ready lamp between two pauses
    task automatic blinks(output int b);
        int dark;
        int t;
        logic last;
        b = 0;
        dark = 0;
        t = 0;
        while (dark < 8 && t < 400) begin
            cyc(1);
            t++;
            dark = ob[0] ? 0 : dark + 1;
        end
        dark = 0;
        last = 1'h0;
        while ((dark < 8 || b == 0) && t < 400) begin
            cyc(1);
            t++;
            b += (ob[0] === 1'h1 && !last);
            dark = ob[0] ? 0 : dark + 1;
            last = ob[0];
        end
    endtask

    // Watchdog
    initial begin
        #20000;
        mismatches++;
        test_done();
    end

    // Main sequence
    initial begin
        cyc(1);
        check("reset", 16'(ob), 16'h0006);
        foreach (rows[i]) begin
            do_reset();
            guard = rows[i].g;
            flt = rows[i].f;
            cyc(8);
            check("outs", mir(), 16'(rows[i].e));
            flt = 6'h00;
            cyc(8);
            check("held", mir(), 16'(rows[i].e));
            if (rows[i].code != 3'h0) begin
                blinks(n);
                check("blinks", 16'(n), 16'(rows[i].code));
            end
        end
        // Warm-up, then shutter and pulses
        do_reset();
        per = 8'h10;
        high = 8'h04;
        guard = 1'h1;
        shut = 1'h1;
        await(6, 8);
        scan(7, 16, hi, run, ris);
        check("warm", 16'(hi), 16'h0000);
        await(7, 40);
        check("lase", 16'({ob[3], ob[4], ob[5], ob[10], ob[11]}),
            16'h001F);
        shut = 1'h0;
        cyc(4);
        scan(7, 20, hi, run, ris);
        check("withdrawn", 16'(hi), 16'h0000);
        shut = 1'h1;
        scan(6, 8, hi, run, ris);
        check("tickle", 16'(hi), 16'h0008);
        await(7, 40);
        // Guard opens with shutter request held, then restored
        guard = 1'h0;
        cyc(4);
        scan(7, 16, hi, run, ris);
        check("open", 16'({hi[0], ob[3], ob[5], ob[12], ob[1]}),
            16'h0002);
        guard = 1'h1;
        await(6, 8);
        scan(7, 16, hi, run, ris);
        check("rewarm", 16'(hi), 16'h0000);
        await(7, 40);
        // Pulse rate above the limit, then back
        per = 8'h06;
        high = 8'h02;
        cyc(10);
        scan(7, 30, hi, run, ris);
        check("freq", 16'(hi), 16'h0000);
        per = 8'h10;
        high = 8'h04;
        await(7, 40);
        // Duty above the limit is clamped and flagged
        high = 8'h0A;
        cyc(40);
        scan(7, 48, hi, run, ris);
        check("duty", 16'({ob[9], run <= 6, hi > 0}), 16'h0007);
        // No-strike flashes the shutter lamp
        high = 8'h04;
        nostrike = 1'h1;
        scan(3, 40, hi, run, ris);
        check("flash", 16'(ris >= 3), 16'h0001);
        humid = 1'h1;
        cyc(4);
        scan(7, 20, hi, run, ris);
        check("humid", 16'(hi), 16'h0000);
        test_done();
    end
endmodule

// [lfs_blink.sv]
/*
 * Lamp blinker: steady level when no code, otherwise a train of blinks
 * equal to the code, a long pause and a repeat; or endless flashing.
 * Assumes synchronous inputs and a synchronised active-low reset.
 */
`timescale 1ns/100ps

module lfs_blink #(
    parameter int unsigned ON_CYC = 32'd1,
    parameter int unsigned OFF_CYC = 32'd1,
    parameter int unsigned PAUSE_CYC = 32'd1
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Lamp requests
    input wire logic steady_i,
    input wire logic cont_i,
    input wire logic [lfs_pkg::CODE_W-1:0] code_i,
    // Lamp drive
    output logic lamp_o
);
    import lfs_pkg::*;

    lfs_blink_st_t st_reg;
    lfs_blink_st_t st_next;
    logic [31:0] cnt_reg;
    logic [31:0] cnt_next;
    logic [CODE_W-1:0] left_reg;
    logic [CODE_W-1:0] left_next;
    logic lamp_reg;
    logic lamp_next;
    wire active = cont_i | (code_i != CODE_NONE);
    wire cnt_done = (cnt_reg == 32'h0);

    // Sequence of blinks, gaps and pause (see R10) (see R21)
    always_comb begin
        st_next = st_reg;
        cnt_next = cnt_done ? cnt_reg : cnt_reg - 32'h1;
        left_next = left_reg;
        unique case (st_reg)
            ST_IDLE: begin
                if (active) begin
                    st_next = ST_ON;
                    cnt_next = ON_CYC - 32'h1;
                    left_next = code_i;
                end
            end
            ST_ON: begin
                if (cnt_done) begin
                    st_next = ST_OFF;
                    cnt_next = OFF_CYC - 32'h1;
                    left_next = left_reg - 3'h1;
                end
            end
            ST_OFF: begin
                if (cnt_done) begin
                    // Continuous flashing never pauses (see R11)
                    if (cont_i || left_reg != CODE_NONE) begin
                        st_next = ST_ON;
                        cnt_next = ON_CYC - 32'h1;
                    end else begin
                        st_next = ST_PAUSE;
                        cnt_next = PAUSE_CYC - 32'h1;
                    end
                end
            end
            ST_PAUSE: begin
                if (cnt_done) begin
                    st_next = ST_IDLE;
                end
            end
        endcase
        if (!active) begin
            st_next = ST_IDLE;
        end
        lamp_next = (st_next == ST_ON) ||
                    (st_next == ST_IDLE && steady_i);
    end

    // State registers
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_reg <= ST_IDLE;
            cnt_reg <= 32'h0;
            left_reg <= 3'h0;
            lamp_reg <= 1'b0;
        end else begin
            st_reg <= st_next;
            cnt_reg <= cnt_next;
            left_reg <= left_next;
            lamp_reg <= lamp_next;
        end
    end

    assign lamp_o = lamp_reg;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    a_pause_dark: assert property ( // see R10
        (st_reg == ST_PAUSE && active) |-> !lamp_o)
        else $error("lamp lit during code pause");
    a_code_loaded: assert property ( // see R10
        (st_reg == ST_IDLE && code_i != 3'h0 && !cont_i)
        |=> (st_reg == ST_ON && left_reg == $past(code_i) && lamp_o))
        else $error("blink code not started");

endmodule

// [lfs_ctrl_model.sv]
/*
 * Model of the machine controller: guard loop, shutter request and a
 * PWM command of set period and high time, in clock cycles.
 * Assumes the bench sets its controls at falling clock edges.
 */
`timescale 1ns/100ps

module lfs_ctrl_model (
    // Clock and controls
    input wire logic clk_i,
    input wire logic guard_i,
    input wire logic shut_i,
    input wire logic [7:0] per_i,
    input wire logic [7:0] high_i,
    // User I/O drive
    output logic guard_o,
    output logic shut_o,
    output logic pulse_o
);
    // ****************************************************
    // Command generation
    // ****************************************************
    logic [7:0] cnt_reg = 8'h00;

    // PWM from a wrapping counter; period zero means no pulses
    initial pulse_o = 1'h0;
    always @(negedge clk_i) begin
        cnt_reg <= (cnt_reg + 8'h01 >= per_i) ? 8'h00 : cnt_reg + 8'h01;
        pulse_o <= (per_i != 8'h00) && (cnt_reg < high_i);
    end

    // Levels pass straight to the pins
    assign guard_o = guard_i;
    assign shut_o = shut_i;
endmodule

// [lfs_pkg.sv]
/*
 * Constants for the laser status and fault sequencer: input bit
 * positions, fault codes, times and the cycle counts derived from them.
 * Assumes a 200 MHz system clock from the laser's internal supply.
 */
// Behaviour
// R01 - Mirrored outputs closed exactly when condition true
// R02 - Ready lamp needs guard and coolant good
// R03 - Ready enables tickle, lasing waits five seconds
// R04 - Shutter request opens shutter; pulses then lase
// R05 - Guard fault keeps shutter dark, no RF; the duty code still blinks the shutter lamp with guard open
// R06 - Guard open: fault, shutter shut, stop lasing
// R07 - Guard fault unlatched; restore repeats warm-up
// R08 - Pulses ignored until shutter open, after withdrawal
// R09 - Tickle continues during shutter transitions
// R10 - Coded faults blink count, pause, repeat
// R11 - No-strike flashes shutter lamp continuously
// R12 - Over-temperature latched until power cycle
// R13 - Under-voltage: one blink, ready output opens
// R14 - Over-voltage: two blinks, ready output opens
// R15 - After power cycle, ready relights, warm-up
// R16 - RF drive switch fault: three blinks
// R17 - Pulse drive fault: four blinks
// R18 - Missing module supply: five blinks, ready opens
// R19 - Pulse frequency over limit disables lasing
// R20 - Duty or width over limit: code, clamp
// R21 - Timings from counters with parameter counts
// R22 - Highest-priority fault code shown, parameter priority

package lfs_pkg;

    // ****************************************************
    // Clock and times
    // ****************************************************
    localparam int CLK_HZ = 200_000_000;
    localparam int CYC_PER_MS = CLK_HZ / 1000;
    localparam int CYC_PER_US = CLK_HZ / 1_000_000;
    localparam int WARM_MS = 5000;
    localparam int PAUSE_MS = 4000;
    localparam int BLINK_ON_MS = 250;
    localparam int BLINK_OFF_MS = 250;
    localparam int SETTLE_MS = 50;
    localparam int WIDTH_US = 600;
    localparam int FREQ_MAX_KHZ = 100;
    localparam int WARM_CYC = WARM_MS * CYC_PER_MS;
    localparam int PAUSE_CYC = PAUSE_MS * CYC_PER_MS;
    localparam int BLINK_ON_CYC = BLINK_ON_MS * CYC_PER_MS;
    localparam int BLINK_OFF_CYC = BLINK_OFF_MS * CYC_PER_MS;
    localparam int SETTLE_CYC = SETTLE_MS * CYC_PER_MS;
    localparam int WIDTH_CYC = WIDTH_US * CYC_PER_US;
    localparam int FREQ_CYC = CYC_PER_MS / FREQ_MAX_KHZ;

    // Duty limit 37.5 % as a fraction
    localparam int DUTY_NUM = 3;
    localparam int DUTY_DEN = 8;

    // ****************************************************
    // Input bit positions
    // ****************************************************
    localparam int IN_W = 11;
    localparam int IN_GUARD = 0;
    localparam int IN_SHUT_REQ = 1;
    localparam int IN_PULSE = 2;
    localparam int IN_OVER_TEMP = 3;
    localparam int IN_UNDER_V = 4;
    localparam int IN_OVER_V = 5;
    localparam int IN_RF_SW = 6;
    localparam int IN_DRV = 7;
    localparam int IN_PRECHG = 8;
    localparam int IN_NO_STRIKE = 9;
    localparam int IN_HUMID = 10;

    // ****************************************************
    // Fault codes
    // ****************************************************
    localparam int CODE_W = 3;
    localparam int N_CODED = 5;
    localparam logic [2:0] CODE_NONE = 3'h0;
    localparam logic [2:0] CODE_DUTY = 3'h3;

    typedef enum logic [1:0] {
        ST_IDLE, ST_ON, ST_OFF, ST_PAUSE
    } lfs_blink_st_t;

endpackage

// [lfs_top.sv]
/*
 * Status and fault sequencer of an RF-excited gas laser: guard loop,
 * coolant check, warm-up, shutter, pulse gating, lamps, mirrored
 * outputs and latched fault codes. Assumes all inputs are pins from
 * isolated receivers and that a DC power cycle asserts RST_N_I.
 */
`timescale 1ns/100ps

module lfs_top #(
    parameter int unsigned WARM_CYC = lfs_pkg::WARM_CYC,
    parameter int unsigned PAUSE_CYC = lfs_pkg::PAUSE_CYC,
    parameter int unsigned BLINK_ON_CYC = lfs_pkg::BLINK_ON_CYC,
    parameter int unsigned BLINK_OFF_CYC = lfs_pkg::BLINK_OFF_CYC,
    parameter int unsigned SETTLE_CYC = lfs_pkg::SETTLE_CYC,
    parameter int unsigned WIDTH_CYC = lfs_pkg::WIDTH_CYC,
    parameter int unsigned FREQ_CYC = lfs_pkg::FREQ_CYC,
    parameter bit PRIO_HIGH_FIRST = 1'b0
) (
    // Clock and reset
    input wire logic CLK_I,
    input wire logic RST_N_I,
    // User and sense inputs
    input wire logic GUARD_LOOP_I,
    input wire logic SHUTTER_REQ_I,
    input wire logic PULSE_CMD_I,
    input wire logic OVER_TEMP_I,
    input wire logic UNDER_VOLT_I,
    input wire logic OVER_VOLT_I,
    input wire logic RF_SWITCH_FAIL_I,
    input wire logic PULSE_DRIVE_FAIL_I,
    input wire logic PRECHARGE_FAIL_I,
    input wire logic NO_STRIKE_I,
    input wire logic HUMIDITY_I,
    // Lamps
    output logic READY_LAMP_O,
    output logic GUARD_LAMP_O,
    output logic COOLANT_HEAT_LAMP_O,
    output logic SHUTTER_LAMP_O,
    output logic EMISSION_LAMP_O,
    // Internal drive
    output logic SHUTTER_DRIVE_O,
    output logic TICKLE_EN_O,
    output logic RF_PULSE_O,
    // Mirrored isolated outputs, 1 = closed
    output logic READY_OUT_O,
    output logic FAULT_OUT_O,
    output logic SHUTTER_OUT_O,
    output logic LASE_OUT_O,
    output logic INTERLOCK_OUT_O
);
    import lfs_pkg::*;

    // ****************************************************
    // Parameter checks
    // ****************************************************
    if (WARM_CYC < 1 || PAUSE_CYC < 1 || BLINK_ON_CYC < 1 ||
        BLINK_OFF_CYC < 1 || SETTLE_CYC < 1 || WIDTH_CYC < 1 ||
        FREQ_CYC < 2) begin : g_bad_param
        $error("lfs_top: counts must be positive");
    end

    // Picks the blink count of the winning coded fault (see R22)
    function automatic logic [CODE_W-1:0] pick_code(
        input logic [N_CODED-1:0] f,
        input logic high_first
    );
        logic [CODE_W-1:0] c;
        c = CODE_NONE;
        for (int i = 0; i < N_CODED; i++) begin
            if (f[i] && (high_first || c == CODE_NONE)) begin
                c = CODE_W'(i + 1);
            end
        end
        return c;
    endfunction

    // ****************************************************
    // Reset release and input synchronisers
    // ****************************************************
    logic rst_meta_reg;
    logic rst_sync_reg;
    logic [IN_W-1:0] in_meta_reg;
    logic [IN_W-1:0] in_reg;
    wire rst_n = rst_sync_reg;
    wire [IN_W-1:0] pins = {HUMIDITY_I, NO_STRIKE_I, PRECHARGE_FAIL_I,
        PULSE_DRIVE_FAIL_I, RF_SWITCH_FAIL_I, OVER_VOLT_I, UNDER_VOLT_I,
        OVER_TEMP_I, PULSE_CMD_I, SHUTTER_REQ_I, GUARD_LOOP_I};

    // Reset leaves through two flops
    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            rst_meta_reg <= 1'b0;
            rst_sync_reg <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_sync_reg <= rst_meta_reg;
        end
    end

    // Two flops on every pin
    always_ff @(posedge CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            in_meta_reg <= 11'h000;
            in_reg <= 11'h000;
        end else begin
            in_meta_reg <= pins;
            in_reg <= in_meta_reg;
        end
    end

    // Named synchronised inputs
    wire guard_s = in_reg[IN_GUARD];
    wire shut_req_s = in_reg[IN_SHUT_REQ];
    wire pulse_s = in_reg[IN_PULSE];
    wire humid_s = in_reg[IN_HUMID];
    wire no_strike_s = in_reg[IN_NO_STRIKE];
    wire [N_CODED-1:0] coded_in = in_reg[IN_PRECHG:IN_UNDER_V];

    // ****************************************************
    // Latched faults, cleared only by power cycle
    // ****************************************************
    logic [N_CODED-1:0] coded_reg;
    logic over_temp_reg;
    wire volt_flt = coded_reg[0] | coded_reg[1] | coded_reg[4];

    // Sticky fault flags (see R12) (see R13) (see R14)
    always_ff @(posedge CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            coded_reg <= 5'h00;
            over_temp_reg <= 1'b0;
        end else begin
            coded_reg <= coded_reg | coded_in; // see R16 see R17 see R18
            over_temp_reg <= over_temp_reg | in_reg[IN_OVER_TEMP];
        end
    end

    // Ready needs guard, coolant and no coded fault (see R02) (see R15)
    wire ready_cond = guard_s & ~over_temp_reg & (coded_reg == 5'h00);

    // ****************************************************
    // Warm-up and shutter timers
    // ****************************************************
    logic [31:0] warm_cnt_reg;
    logic warm_done_reg;
    logic [31:0] shut_cnt_reg;
    logic shut_full_reg;
    wire shut_cmd = ready_cond & shut_req_s;

    // Warm-up restarts whenever ready drops (see R03) (see R07)
    always_ff @(posedge CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            warm_cnt_reg <= 32'h0;
            warm_done_reg <= 1'b0;
        end else if (!ready_cond) begin
            warm_cnt_reg <= 32'h0;
            warm_done_reg <= 1'b0;
        end else if (!warm_done_reg) begin
            warm_done_reg <= (warm_cnt_reg == WARM_CYC - 32'h1); // see R21
            warm_cnt_reg <= warm_cnt_reg + 32'h1;
        end
    end

    // Shutter settle time after each open command (see R08)
    always_ff @(posedge CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            shut_cnt_reg <= 32'h0;
            shut_full_reg <= 1'b0;
        end else if (!shut_cmd) begin
            shut_cnt_reg <= 32'h0;
            shut_full_reg <= 1'b0;
        end else if (!shut_full_reg) begin
            shut_full_reg <= (shut_cnt_reg == SETTLE_CYC - 32'h1);
            shut_cnt_reg <= shut_cnt_reg + 32'h1;
        end
    end

    // ****************************************************
    // Pulse command measurement
    // ****************************************************
    logic pulse_d_reg;
    logic [31:0] per_cnt_reg;
    logic [31:0] hi_cnt_reg;
    logic [31:0] period_reg;
    logic freq_flt_reg;
    logic dw_flt_reg;
    wire rise = pulse_s & ~pulse_d_reg;
    wire [63:0] hi_scaled = 64'(hi_cnt_reg) * 64'(DUTY_DEN);
    wire [63:0] per_scaled = 64'(per_cnt_reg) * 64'(DUTY_NUM);
    wire duty_over = hi_scaled > per_scaled;
    wire width_over = hi_cnt_reg > WIDTH_CYC;
    wire [31:0] duty_lim =
        32'((64'(period_reg) * 64'(DUTY_NUM)) / 64'(DUTY_DEN));
    wire [31:0] hi_lim = (duty_lim < WIDTH_CYC) ? duty_lim : WIDTH_CYC;

    // Period and high-time counters, saturating
    always_ff @(posedge CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            pulse_d_reg <= 1'b0;
            per_cnt_reg <= 32'h0;
            hi_cnt_reg <= 32'h0;
            period_reg <= 32'h0;
        end else begin
            pulse_d_reg <= pulse_s;
            if (rise) begin
                period_reg <= per_cnt_reg;
                per_cnt_reg <= 32'h1;
                hi_cnt_reg <= 32'h1;
            end else begin
                if (per_cnt_reg != 32'hFFFFFFFF) begin
                    per_cnt_reg <= per_cnt_reg + 32'h1;
                end
                if (pulse_s && hi_cnt_reg != 32'hFFFFFFFF) begin
                    hi_cnt_reg <= hi_cnt_reg + 32'h1;
                end
            end
        end
    end

    // Limit conditions; recover as soon as the command is back in range
    always_ff @(posedge CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            freq_flt_reg <= 1'b0;
            dw_flt_reg <= 1'b0;
        end else begin
            if (rise) begin
                freq_flt_reg <= (per_cnt_reg < FREQ_CYC); // see R19
                dw_flt_reg <= duty_over | width_over; // see R20
            end else begin
                if (per_cnt_reg >= FREQ_CYC) begin
                    freq_flt_reg <= 1'b0; // see R19
                end
                if (pulse_s && width_over) begin
                    dw_flt_reg <= 1'b1; // see R20
                end
            end
        end
    end

    // ****************************************************
    // Lasing gate and registered outputs
    // ****************************************************
    // All conditions for emission (see R04) (see R05) (see R06) (see R08)
    wire lase_en = ready_cond & warm_done_reg & shut_full_reg &
                   shut_req_s & ~freq_flt_reg & ~humid_s;
    // Pulse clamped to duty and width limits (see R20)
    wire clamp_ok = rise | (hi_cnt_reg < hi_lim);
    wire rf_next = lase_en & pulse_s & clamp_ok;

    logic shut_drive_reg;
    logic tickle_reg;
    logic rf_reg;
    logic ready_out_reg;
    logic fault_out_reg;
    logic intl_out_reg;

    // Drive and mirror outputs (see R01)
    always_ff @(posedge CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            shut_drive_reg <= 1'b0;
            tickle_reg <= 1'b0;
            rf_reg <= 1'b0;
            ready_out_reg <= 1'b0;
            fault_out_reg <= 1'b0;
            intl_out_reg <= 1'b0;
        end else begin
            shut_drive_reg <= shut_cmd; // see R04 see R05 see R06
            tickle_reg <= ready_cond; // see R03 see R09
            rf_reg <= rf_next;
            ready_out_reg <= guard_s & ~over_temp_reg & ~volt_flt;
            fault_out_reg <= over_temp_reg | dw_flt_reg; // see R12
            intl_out_reg <= ~guard_s;
        end
    end

    assign SHUTTER_DRIVE_O = shut_drive_reg;
    assign TICKLE_EN_O = tickle_reg;
    assign RF_PULSE_O = rf_reg;
    assign EMISSION_LAMP_O = rf_reg;
    assign LASE_OUT_O = rf_reg;
    assign SHUTTER_OUT_O = shut_drive_reg;
    assign READY_OUT_O = ready_out_reg;
    assign FAULT_OUT_O = fault_out_reg;
    assign INTERLOCK_OUT_O = intl_out_reg;
    assign GUARD_LAMP_O = ~intl_out_reg;
    assign COOLANT_HEAT_LAMP_O = ~fault_out_reg | ~over_temp_reg;

    // ****************************************************
    // Blinking lamps
    // ****************************************************
    // Ready lamp shows the winning coded fault (see R10) (see R22)
    lfs_blink #(
        .ON_CYC(BLINK_ON_CYC),
        .OFF_CYC(BLINK_OFF_CYC),
        .PAUSE_CYC(PAUSE_CYC)
    ) u_ready_blink (
        .clk_i(CLK_I),
        .rst_n_i(rst_n),
        .steady_i(ready_cond),
        .cont_i(1'b0),
        .code_i(pick_code(coded_reg, PRIO_HIGH_FIRST)),
        .lamp_o(READY_LAMP_O)
    );

    // Shutter lamp: no-strike flash, duty code (see R11) (see R20)
    lfs_blink #(
        .ON_CYC(BLINK_ON_CYC),
        .OFF_CYC(BLINK_OFF_CYC),
        .PAUSE_CYC(PAUSE_CYC)
    ) u_shut_blink (
        .clk_i(CLK_I),
        .rst_n_i(rst_n),
        .steady_i(shut_cmd),
        .cont_i(no_strike_s & ready_cond),
        .code_i(dw_flt_reg ? CODE_DUTY : CODE_NONE),
        .lamp_o(SHUTTER_LAMP_O)
    );

    // ****************************************************
    // Assertions
    // ****************************************************
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!rst_n);

    sequence s_ready_up;
        $rose(ready_cond);
    endsequence
    sequence s_held_off;
        !lase_en [*8];
    endsequence

    a_warm_holdoff: assert property ( // see R03
        s_ready_up |-> s_held_off)
        else $error("lasing allowed before warm-up");
    a_guard_stop: assert property ( // see R06
        !guard_s |=> (!RF_PULSE_O && !SHUTTER_DRIVE_O && INTERLOCK_OUT_O))
        else $error("guard open but shutter or RF on");
    a_guard_dark: assert property ( // see R05
        (!guard_s && !no_strike_s && !dw_flt_reg) |=> !SHUTTER_LAMP_O)
        else $error("shutter lamp lit with guard fault");
    a_shut_wait: assert property ( // see R08
        (!shut_full_reg || !shut_req_s) |=> !RF_PULSE_O)
        else $error("pulse passed before shutter open");
    a_tickle_kept: assert property ( // see R09
        (ready_cond && shut_req_s && !shut_full_reg) |=> TICKLE_EN_O)
        else $error("tickle dropped during shutter move");
    a_temp_latch: assert property ( // see R12
        $rose(over_temp_reg) |=> (over_temp_reg && !ready_cond) [*4]
        ##0 (FAULT_OUT_O && !COOLANT_HEAT_LAMP_O))
        else $error("over-temperature not latched");
    a_volt_open: assert property ( // see R13
        (coded_reg[0] || coded_reg[1]) |=> (!READY_OUT_O && volt_flt))
        else $error("ready output closed on voltage fault");
    a_freq_block: assert property ( // see R19
        freq_flt_reg |=> !RF_PULSE_O)
        else $error("lasing above frequency limit");
    a_width_clamp: assert property ( // see R20
        (pulse_s && !rise && hi_cnt_reg >= WIDTH_CYC) |=> !RF_PULSE_O)
        else $error("pulse not clamped to width limit");
    a_ready_mirror: assert property ( // see R01
        READY_OUT_O == $past(guard_s && !over_temp_reg && !volt_flt))
        else $error("ready output does not mirror state");

endmodule
